// ### rtl/bbsl_loader.sv
// boot block stream loader: header parse, memory writes, final overwrite
`timescale 1ns/1ps
module bbsl_loader #(
  parameter int W = 48
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic extValid,
  input wire logic [W-1:0] extData,
  output logic extReady,
  input wire logic lnkValid,
  input wire logic [W-1:0] lnkData,
  output logic lnkReady,
  output logic memWrite,
  output logic memProgram,
  output logic [2:0] memWidth,
  output logic [31:0] memAddr,
  output logic [63:0] memData,
  input wire logic memReady,
  output logic dmaOverwrite,
  output logic setupPulse,
  output logic restorePulse,
  output logic [31:0] systemConfigRegister,
  output logic [31:0] dmaChannelControl,
  output logic [31:0] linkPortControl,
  output logic [47:0] wideTransferRegister,
  output logic vectorTableInternal,
  output logic runApp,
  output logic [31:0] runAddr,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata
);
  typedef struct packed {
    bbsl_pkg::bbsl_state_e st;
    logic [3:0] setupCnt;
    logic [15:0] tag;
    logic [31:0] addr;
    logic [15:0] cnt;
    logic isProg;
    logic [2:0] width;
    logic portSel;
    logic vectorSelect;
    logic noBoot;
    logic errFlag;
    logic doneFlag;
    logic [31:0] ldrBase;
    logic [15:0] ldrLen;
    logic memWrite;
    logic memProgram;
    logic [2:0] memWidth;
    logic [31:0] memAddr;
    logic [63:0] memData;
    logic dmaOverwrite;
    logic setupPulse;
    logic restorePulse;
    logic [31:0] sysCfg;
    logic [31:0] dmaCtl;
    logic [31:0] lnkCtl;
    logic [47:0] wide;
    logic vtInt;
    logic runApp;
    logic [31:0] runAddr;
    logic [31:0] rdata;
  } bbsl_loader_s;
  bbsl_loader_s q, next_q;
  logic muxValid, bufInReady, bufValid, bufReady;
  logic [W-1:0] muxData, bufWord;
  logic [15:0] tagIn;
  logic busy, memFree;

  // ==========================================================
  // boot port path: selector then two-entry buffer
  bbsl_port_mux #(.W(W)) uMux (
    .sel(q.portSel),
    .extValid(extValid),
    .extData(extData),
    .extReady(extReady),
    .lnkValid(lnkValid),
    .lnkData(lnkData),
    .lnkReady(lnkReady),
    .outValid(muxValid),
    .outData(muxData),
    .outReady(bufInReady)
  );
  bbsl_skid #(.W(W)) uBuf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(muxValid),
    .inReady(bufInReady),
    .inData(muxData),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufWord)
  );

  // ==========================================================
  // a pending memory write blocks the next one until accepted
  assign memFree = !q.memWrite || memReady;
  assign tagIn = bufWord[bbsl_pkg::TAG_LSB +: bbsl_pkg::TAG_W];
  assign busy = (q.st != bbsl_pkg::ST_IDLE) && (q.st != bbsl_pkg::ST_DONE)
    && (q.st != bbsl_pkg::ST_ERR);
  // words are consumed only in states that read the stream
  assign bufReady = memFree && (q.st == bbsl_pkg::ST_HDR0 || q.st == bbsl_pkg::ST_HDR1
    || q.st == bbsl_pkg::ST_BODY || q.st == bbsl_pkg::ST_FINWORD || q.st == bbsl_pkg::ST_OVER);

  // ==========================================================
  // next-state and output logic
  always_comb begin
    next_q = q;
    next_q.setupPulse = 1'b0;
    next_q.restorePulse = 1'b0;
    next_q.rdata = '0;
    if (q.memWrite && memReady) begin
      next_q.memWrite = 1'b0;
    end
    // table location: booted forces internal, no-boot obeys select bit
    next_q.vtInt = q.noBoot ? q.vectorSelect : 1'b1;
    case (q.st)
      bbsl_pkg::ST_IDLE: begin
        next_q.runApp = 1'b0;
      end
      bbsl_pkg::ST_SETUP: begin
        // core set-up runs before any memory is loaded
        next_q.setupCnt = q.setupCnt - 4'h1;
        if (q.setupCnt == 4'h1) begin
          next_q.setupPulse = 1'b1;
          next_q.st = bbsl_pkg::ST_HDR0;
        end
      end
      bbsl_pkg::ST_HDR0: begin
        if (bufValid && bufReady) begin
          next_q.tag = tagIn;
          next_q.st = bbsl_pkg::ST_HDR1;
          case (tagIn)
            bbsl_pkg::TAG_FINAL: begin
              next_q.st = bbsl_pkg::ST_FINWORD;
            end
            bbsl_pkg::TAG_ZDM16, bbsl_pkg::TAG_IDM16: begin
              next_q.isProg = 1'b0;
              next_q.width = bbsl_pkg::WID_16;
            end
            bbsl_pkg::TAG_ZDM32, bbsl_pkg::TAG_IDM32: begin
              next_q.isProg = 1'b0;
              next_q.width = bbsl_pkg::WID_32;
            end
            bbsl_pkg::TAG_ZDM40: begin
              next_q.isProg = 1'b0;
              next_q.width = bbsl_pkg::WID_40;
            end
            bbsl_pkg::TAG_ZDM64, bbsl_pkg::TAG_IDM64: begin
              next_q.isProg = 1'b0;
              next_q.width = bbsl_pkg::WID_64;
            end
            bbsl_pkg::TAG_ZPM16, bbsl_pkg::TAG_IPM16: begin
              next_q.isProg = 1'b1;
              next_q.width = bbsl_pkg::WID_16;
            end
            bbsl_pkg::TAG_ZPM32, bbsl_pkg::TAG_IPM32: begin
              next_q.isProg = 1'b1;
              next_q.width = bbsl_pkg::WID_32;
            end
            bbsl_pkg::TAG_ZPM40: begin
              next_q.isProg = 1'b1;
              next_q.width = bbsl_pkg::WID_40;
            end
            bbsl_pkg::TAG_ZPM48, bbsl_pkg::TAG_IPM48: begin
              next_q.isProg = 1'b1;
              next_q.width = bbsl_pkg::WID_48;
            end
            bbsl_pkg::TAG_ZPM64, bbsl_pkg::TAG_IPM64: begin
              next_q.isProg = 1'b1;
              next_q.width = bbsl_pkg::WID_64;
            end
            default: begin
              next_q.errFlag = 1'b1;
              next_q.st = bbsl_pkg::ST_ERR;
            end
          endcase
        end
      end
      bbsl_pkg::ST_HDR1: begin
        if (bufValid && bufReady) begin
          next_q.addr = bufWord[bbsl_pkg::ADDR_LSB +: bbsl_pkg::ADDR_W];
          next_q.cnt = bufWord[bbsl_pkg::CNT_LSB +: bbsl_pkg::CNT_W];
          if (bufWord[bbsl_pkg::CNT_LSB +: bbsl_pkg::CNT_W] == 16'h0000) begin
            next_q.st = bbsl_pkg::ST_HDR0;
          end else if (q.tag == bbsl_pkg::TAG_IDM16 || q.tag == bbsl_pkg::TAG_IDM32
              || q.tag == bbsl_pkg::TAG_IDM64 || q.tag == bbsl_pkg::TAG_IPM16
              || q.tag == bbsl_pkg::TAG_IPM32 || q.tag == bbsl_pkg::TAG_IPM48
              || q.tag == bbsl_pkg::TAG_IPM64) begin
            next_q.st = bbsl_pkg::ST_BODY;
          end else begin
            next_q.st = bbsl_pkg::ST_ZERO;
          end
        end
      end
      bbsl_pkg::ST_BODY: begin
        // each body word to the next address
        if (bufValid && bufReady) begin
          next_q.memWrite = 1'b1;
          next_q.memProgram = q.isProg;
          next_q.memWidth = q.width;
          next_q.memAddr = q.addr;
          next_q.memData = {16'h0000, bufWord};
          next_q.addr = q.addr + 32'h1;
          next_q.cnt = q.cnt - 16'h1;
          if (q.cnt == 16'h1) begin
            next_q.st = bbsl_pkg::ST_HDR0;
          end
        end
      end
      bbsl_pkg::ST_ZERO: begin
        // zero fill takes no stream words
        if (memFree) begin
          next_q.memWrite = 1'b1;
          next_q.memProgram = q.isProg;
          next_q.memWidth = q.width;
          next_q.memAddr = q.addr;
          next_q.memData = '0;
          next_q.addr = q.addr + 32'h1;
          next_q.cnt = q.cnt - 16'h1;
          if (q.cnt == 16'h1) begin
            next_q.st = bbsl_pkg::ST_HDR0;
          end
        end
      end
      bbsl_pkg::ST_FINWORD: begin
        if (bufValid && bufReady) begin
          next_q.wide = bufWord;
          next_q.st = bbsl_pkg::ST_FINVEC;
        end
      end
      bbsl_pkg::ST_FINVEC: begin
        // park a return at the first vector while the overwrite runs
        if (memFree) begin
          next_q.memWrite = 1'b1;
          next_q.memProgram = 1'b1;
          next_q.memWidth = bbsl_pkg::WID_48;
          next_q.memAddr = bbsl_pkg::VEC_FIRST;
          next_q.memData = {16'h0000, bbsl_pkg::INSTR_RTI};
          next_q.dmaOverwrite = 1'b1;
          next_q.addr = q.ldrBase;
          next_q.cnt = q.ldrLen;
          next_q.st = (q.ldrLen == 16'h0000) ? bbsl_pkg::ST_RESTORE : bbsl_pkg::ST_OVER;
        end
      end
      bbsl_pkg::ST_OVER: begin
        // last transfer: loader region filled from the stream source side
        next_q.st = bbsl_pkg::ST_OVER;
        if (bufValid && bufReady) begin
          next_q.memWrite = 1'b1;
          next_q.memProgram = 1'b1;
          next_q.memWidth = bbsl_pkg::WID_48;
          next_q.memAddr = q.addr;
          next_q.memData = {16'h0000, bufWord};
          next_q.addr = q.addr + 32'h1;
          next_q.cnt = q.cnt - 16'h1;
          if (q.cnt == 16'h1) begin
            next_q.st = bbsl_pkg::ST_RESTORE;
          end
        end
      end
      bbsl_pkg::ST_RESTORE: begin
        if (memFree) begin
          next_q.sysCfg = bbsl_pkg::SYSCFG_RST;
          next_q.dmaCtl = bbsl_pkg::DMACTL_RST;
          next_q.lnkCtl = bbsl_pkg::LINKCTL_RST;
          next_q.dmaOverwrite = 1'b0;
          next_q.restorePulse = 1'b1;
          next_q.runApp = 1'b1;
          next_q.runAddr = bbsl_pkg::VEC_SECOND;
          next_q.doneFlag = 1'b1;
          next_q.st = bbsl_pkg::ST_DONE;
        end
      end
      bbsl_pkg::ST_DONE: begin
        next_q.st = bbsl_pkg::ST_DONE;
      end
      bbsl_pkg::ST_ERR: begin
        next_q.st = bbsl_pkg::ST_ERR;
      end
      default: begin
        next_q.st = bbsl_pkg::ST_IDLE;
      end
    endcase
    // ========================================================
    // register port; port, no-boot and loader region frozen while a boot runs
    if (regWrite) begin
      case (regAddr)
        bbsl_pkg::REG_CTRL: begin
          next_q.vectorSelect = regWdata[bbsl_pkg::CTRL_VTSEL];
          if (!busy) begin
            next_q.portSel = regWdata[bbsl_pkg::CTRL_PORT];
            next_q.noBoot = regWdata[bbsl_pkg::CTRL_NOBOOT];
            if (regWdata[bbsl_pkg::CTRL_START] && !regWdata[bbsl_pkg::CTRL_NOBOOT]) begin
              next_q.st = bbsl_pkg::ST_SETUP;
              next_q.setupCnt = bbsl_pkg::SETUP_CYC;
              next_q.errFlag = 1'b0;
              next_q.doneFlag = 1'b0;
              next_q.runApp = 1'b0;
            end
          end
        end
        bbsl_pkg::REG_LDR_BASE: begin
          if (!busy) begin
            next_q.ldrBase = regWdata;
          end
        end
        bbsl_pkg::REG_LDR_LEN: begin
          if (!busy) begin
            next_q.ldrLen = regWdata[15:0];
          end
        end
        bbsl_pkg::REG_SYSCFG: begin
          next_q.sysCfg = regWdata;
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        bbsl_pkg::REG_CTRL: next_q.rdata = {28'h0, q.noBoot, q.vectorSelect, q.portSel, busy};
        bbsl_pkg::REG_STAT: next_q.rdata = {20'h0, 4'(q.st), 5'h0, q.vtInt, q.errFlag,
          q.doneFlag};
        bbsl_pkg::REG_WIDE_LO: next_q.rdata = q.wide[31:0];
        bbsl_pkg::REG_WIDE_HI: next_q.rdata = {16'h0000, q.wide[47:32]};
        bbsl_pkg::REG_LDR_BASE: next_q.rdata = q.ldrBase;
        bbsl_pkg::REG_LDR_LEN: next_q.rdata = {16'h0000, q.ldrLen};
        bbsl_pkg::REG_SYSCFG: next_q.rdata = q.sysCfg;
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= bbsl_pkg::ST_IDLE;
      q.ldrBase <= bbsl_pkg::LDR_BASE_RST;
      q.ldrLen <= bbsl_pkg::LDR_LEN_RST;
      q.sysCfg <= bbsl_pkg::SYSCFG_RST;
      q.vectorSelect <= 1'b0;
      q.vtInt <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign memWrite = q.memWrite;
  assign memProgram = q.memProgram;
  assign memWidth = q.memWidth;
  assign memAddr = q.memAddr;
  assign memData = q.memData;
  assign dmaOverwrite = q.dmaOverwrite;
  assign setupPulse = q.setupPulse;
  assign restorePulse = q.restorePulse;
  assign systemConfigRegister = q.sysCfg;
  assign dmaChannelControl = q.dmaCtl;
  assign linkPortControl = q.lnkCtl;
  assign wideTransferRegister = q.wide;
  assign vectorTableInternal = q.vtInt;
  assign runApp = q.runApp;
  assign runAddr = q.runAddr;
  assign regRdata = q.rdata;
endmodule

// ### rtl/bbsl_pkg.sv
// package of constants and types for the boot block stream loader
// How it works
// - first header word low 16 bits tag
// - second word: address high, count low
// - initialize blocks carry counted 48-bit body words
// - zero blocks have header only, no body
// - decode data-memory zero and initialize tags
// - decode program-memory zero and initialize tags
// - write body or zeros at consecutive addresses
// - headers come through selected boot port
// - tag zero: read final 48-bit word
// - final overwrite of loader region, restore defaults
// - first vector return, run from second
// - set up core state before loading memory
// - booted means internal vector table
// - no-boot: select bit chooses table location
// - select bit ignored when booted, resets 0
package bbsl_pkg;
  // ==========================================================
  // stream word layout
  localparam int WORD_W = 48;
  localparam int TAG_LSB = 0;
  localparam int TAG_W = 16;
  localparam int CNT_LSB = 0;
  localparam int CNT_W = 16;
  localparam int ADDR_LSB = 16;
  localparam int ADDR_W = 32;
  // ==========================================================
  // block tags
  localparam logic [15:0] TAG_FINAL = 16'h0000;
  localparam logic [15:0] TAG_ZDM16 = 16'h0001;
  localparam logic [15:0] TAG_ZDM32 = 16'h0002;
  localparam logic [15:0] TAG_ZDM40 = 16'h0003;
  localparam logic [15:0] TAG_IDM16 = 16'h0004;
  localparam logic [15:0] TAG_IDM32 = 16'h0005;
  localparam logic [15:0] TAG_ZPM16 = 16'h0007;
  localparam logic [15:0] TAG_ZPM32 = 16'h0008;
  localparam logic [15:0] TAG_ZPM40 = 16'h0009;
  localparam logic [15:0] TAG_ZPM48 = 16'h000A;
  localparam logic [15:0] TAG_IPM16 = 16'h000B;
  localparam logic [15:0] TAG_IPM32 = 16'h000C;
  localparam logic [15:0] TAG_IPM48 = 16'h000E;
  localparam logic [15:0] TAG_ZDM64 = 16'h000F;
  localparam logic [15:0] TAG_IDM64 = 16'h0010;
  localparam logic [15:0] TAG_ZPM64 = 16'h0011;
  localparam logic [15:0] TAG_IPM64 = 16'h0012;
  // ==========================================================
  // memory width codes shown on the write port
  localparam logic [2:0] WID_16 = 3'h0;
  localparam logic [2:0] WID_32 = 3'h1;
  localparam logic [2:0] WID_40 = 3'h2;
  localparam logic [2:0] WID_48 = 3'h3;
  localparam logic [2:0] WID_64 = 3'h4;
  // ==========================================================
  // loader region, reset vector, defaults, setup length
  localparam logic [31:0] LDR_BASE_RST = 32'h0002_0000;
  localparam logic [15:0] LDR_LEN_RST = 16'h0100;
  localparam logic [31:0] VEC_FIRST = 32'h0002_0004;
  localparam logic [31:0] VEC_SECOND = 32'h0002_0005;
  localparam logic [47:0] INSTR_RTI = 48'h0A3E_0000_0000;
  localparam logic [31:0] SYSCFG_RST = 32'h0000_0010;
  localparam logic [31:0] DMACTL_RST = 32'h0000_0000;
  localparam logic [31:0] LINKCTL_RST = 32'h0000_0000;
  localparam logic [3:0] SETUP_CYC = 4'h4;
  // ==========================================================
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_WIDE_LO = 4'h2;
  localparam logic [3:0] REG_WIDE_HI = 4'h3;
  localparam logic [3:0] REG_LDR_BASE = 4'h4;
  localparam logic [3:0] REG_LDR_LEN = 4'h5;
  localparam logic [3:0] REG_SYSCFG = 4'h6;
  localparam int CTRL_START = 0;
  localparam int CTRL_PORT = 1;
  localparam int CTRL_VTSEL = 2;
  localparam int CTRL_NOBOOT = 3;
  // ==========================================================
  // loader states
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_HDR0, ST_HDR1, ST_BODY, ST_ZERO,
    ST_FINWORD, ST_FINVEC, ST_OVER, ST_RESTORE, ST_DONE, ST_ERR
  } bbsl_state_e;
endpackage

// ### rtl/bbsl_skid.sv
// two-entry buffer between boot port and loader
`timescale 1ns/1ps
module bbsl_skid #(
  parameter int W = 48
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } bbsl_skid_s;
  bbsl_skid_s q, next_q;
  logic push, pop;
  // ==========================================================
  // ready only from registered fill, so the source sees true back-pressure
  assign inReady = (q.cnt != 2'h2);
  assign outValid = (q.cnt != 2'h0);
  assign outData = q.e0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always_comb begin
    next_q = q;
    if (pop) begin
      next_q.e0 = q.e1;
    end
    if (push) begin
      if (q.cnt == 2'h0 || (q.cnt == 2'h1 && pop)) begin
        next_q.e0 = inData;
      end else begin
        next_q.e1 = inData;
      end
    end
    next_q.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// ### rtl/bbsl_port_mux.sv
// selects external or link boot port into the loader path
`timescale 1ns/1ps
module bbsl_port_mux #(
  parameter int W = 48
) (
  input wire logic sel,
  input wire logic extValid,
  input wire logic [W-1:0] extData,
  output logic extReady,
  input wire logic lnkValid,
  input wire logic [W-1:0] lnkData,
  output logic lnkReady,
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  // ==========================================================
  // unselected port is held off; it never sees ready
  always_comb begin
    outValid = sel ? lnkValid : extValid;
    outData = sel ? lnkData : extData;
    extReady = !sel && outReady;
    lnkReady = sel && outReady;
  end
endmodule

// ### verif/bbsl_monitor.sv
// port-level checker of the boot block stream loader
`timescale 1ns/1ps
module bbsl_monitor #(
  parameter int W = 48
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic extReady,
  input wire logic lnkReady,
  input wire logic memWrite,
  input wire logic memProgram,
  input wire logic [2:0] memWidth,
  input wire logic [31:0] memAddr,
  input wire logic [63:0] memData,
  input wire logic memReady,
  input wire logic dmaOverwrite,
  input wire logic setupPulse,
  input wire logic restorePulse,
  input wire logic [31:0] systemConfigRegister,
  input wire logic [31:0] dmaChannelControl,
  input wire logic [31:0] linkPortControl,
  input wire logic vectorTableInternal,
  input wire logic runApp,
  input wire logic [31:0] runAddr,
  input wire logic regRead,
  input wire logic [31:0] regRdata
);
  // ==========================================================
  // helper state
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic setupSeen;
  // remembers core set-up; a later boot cannot clear it, so this is a weak bound
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      setupSeen <= 1'b0;
    end else if (setupPulse) begin
      setupSeen <= 1'b1;
    end
  end
  // ==========================================================
  // assertions
  a_write_holds: assert property (memWrite && !memReady |=>
    memWrite && $stable(memAddr) && $stable(memData)) else $error("write dropped early");
  a_setup_first: assert property (memWrite |-> setupSeen)
    else $error("memory write before set-up");
  a_one_port: assert property (!(extReady && lnkReady))
    else $error("both boot ports ready");
  a_restore_dflt: assert property (restorePulse |-> ##[0:1]
    (systemConfigRegister == bbsl_pkg::SYSCFG_RST && dmaChannelControl == bbsl_pkg::DMACTL_RST
    && linkPortControl == bbsl_pkg::LINKCTL_RST)) else $error("defaults not restored");
  a_final_pm48: assert property (memWrite && dmaOverwrite &&
    memAddr != bbsl_pkg::VEC_FIRST |-> memProgram && memWidth == bbsl_pkg::WID_48)
    else $error("overwrite word not program 48");
  a_run_second: assert property (runApp |->
    runAddr == bbsl_pkg::VEC_SECOND && !dmaOverwrite) else $error("bad run address");
  a_boot_vtint: assert property (runApp |-> vectorTableInternal)
    else $error("booted with external table");
  a_rdata_slot: assert property (regRdata != 32'h0 |-> $past(regRead))
    else $error("read data outside its slot");
  cover property (memWrite && !memReady);
  cover property ($rose(runApp));
  cover property (restorePulse);
  cover property (lnkReady);
endmodule
bind bbsl_loader bbsl_monitor #(.W(W)) u_mon (.core_clk, .sys_rst, .extReady, .lnkReady,
  .memWrite, .memProgram, .memWidth, .memAddr, .memData, .memReady, .dmaOverwrite,
  .setupPulse, .restorePulse, .systemConfigRegister, .dmaChannelControl, .linkPortControl,
  .vectorTableInternal, .runApp, .runAddr, .regRead, .regRdata);

// ### verif/bbsl_boot_src.sv
// boot source model: streams queued 48-bit words over valid-ready
`timescale 1ns/1ps
module bbsl_boot_src (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic ready,
  output logic valid,
  output logic [47:0] data
);
  // ==========================================================
  // word queue and handshake
  logic [47:0] q[$];
  logic gap;
  // a word holds until taken; idle cycles show the inverse so stale data never matches
  always @(posedge core_clk or posedge sys_rst) begin : step
    int n;
    n = q.size();
    if (sys_rst) begin
      valid <= 1'b0;
      data <= 48'h0;
      gap <= 1'b0;
    end else if (!(valid && !ready)) begin
      if (valid) begin
        q.delete(0);
        n--;
      end
      gap <= slow & ~gap;
      if (n > 0 && !gap) begin
        valid <= 1'b1;
        data <= q[0];
      end else begin
        valid <= 1'b0;
        data <= ~data;
      end
    end
  end
  task push(input logic [47:0] w);
    q.push_back(w);
  endtask
endmodule

// ### verif/testbench.sv
// self-checking bench of the boot block stream loader
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals, design and partners
  logic core_clk, sys_rst, extValid, lnkValid, memReady, regWrite, regRead, extReady, lnkReady;
  logic memWrite, memProgram, dmaOverwrite, setupPulse, restorePulse, vectorTableInternal, runApp;
  logic slowSrc;
  logic [2:0] memWidth;
  logic [3:0] regAddr;
  logic [31:0] memAddr, systemConfigRegister, dmaChannelControl, linkPortControl, runAddr;
  logic [31:0] regWdata, regRdata, rv;
  logic [47:0] extData, lnkData, wideTransferRegister;
  logic [63:0] memData;
  logic [31:0] qa[$];
  logic [63:0] qd[$];
  logic [3:0] qpw[$];
  int n_errors = 0;
  int check_count = 0;
  bbsl_loader #(.W(48)) dut (.core_clk, .sys_rst, .extValid, .extData, .extReady, .lnkValid,
    .lnkData, .lnkReady, .memWrite, .memProgram, .memWidth, .memAddr, .memData, .memReady,
    .dmaOverwrite, .setupPulse, .restorePulse, .systemConfigRegister, .dmaChannelControl,
    .linkPortControl, .wideTransferRegister, .vectorTableInternal, .runApp, .runAddr,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata);
  bbsl_boot_src srcExt (.core_clk, .sys_rst, .slow(slowSrc), .ready(extReady), .valid(extValid),
    .data(extData));
  bbsl_boot_src srcLnk (.core_clk, .sys_rst, .slow(!slowSrc), .ready(lnkReady), .valid(lnkValid),
    .data(lnkData));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // memory stalls every other cycle, so a write issued into a stall must hold
  always @(posedge core_clk) begin
    memReady <= ~memReady;
    if (memWrite === 1'b1 && memReady === 1'b1) begin
      qa.push_back(memAddr);
      qd.push_back(memData);
      qpw.push_back({memProgram, memWidth});
    end
  end
  // ==========================================================
  // shared tasks
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 rv = regRdata;
  endtask
  // pw of F skips the memory kind check
  task expw(input logic [31:0] a, input logic [63:0] d, input logic [63:0] m,
            input logic [3:0] pw);
    if (qa.size() == 0) begin
      chk(64'h1, 64'h0);
    end else begin
      chk(qa.pop_front(), a);
      chk(qd.pop_front() & m, d);
      if (pw != 4'hF) chk(qpw.pop_front(), pw);
      else void'(qpw.pop_front());
    end
  endtask
  task end_sim;
    $display("TB: errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    rd(bbsl_pkg::REG_LDR_BASE);
    chk(rv, bbsl_pkg::LDR_BASE_RST);
    rd(bbsl_pkg::REG_LDR_LEN);
    chk(rv, 32'h100);
    rd(bbsl_pkg::REG_SYSCFG);
    chk(rv, 32'h10);
    rd(4'hF);
    chk(rv, 32'h0);
    chk(vectorTableInternal, 1'b1);
  endtask
  task t_noboot;
    wr(bbsl_pkg::REG_CTRL, 32'h8);
    repeat (2) @(posedge core_clk);
    chk(vectorTableInternal, 1'b0);
    wr(bbsl_pkg::REG_CTRL, 32'hC);
    repeat (2) @(posedge core_clk);
    chk(vectorTableInternal, 1'b1);
    wr(bbsl_pkg::REG_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(vectorTableInternal, 1'b1);
  endtask
  // every tag once, zero blocks two words long, then the final overwrite
  task t_boot;
    logic [15:0] tg[16];
    logic [4:0] at[16];
    tg = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h7, 16'h8, 16'h9, 16'hA, 16'hB, 16'hC,
           16'hE, 16'hF, 16'h10, 16'h11, 16'h12};
    at = '{5'h00, 5'h01, 5'h02, 5'h10, 5'h11, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h18, 5'h19,
           5'h1B, 5'h04, 5'h14, 5'h0C, 5'h1C};
    wr(bbsl_pkg::REG_LDR_LEN, 32'h2);
    wr(bbsl_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 16; i++) begin
      srcExt.push({32'hFFFF_FFFF, tg[i]});
      srcExt.push({32'h100 + 4 * i, at[i][4] ? 16'h1 : 16'h2});
      if (at[i][4]) srcExt.push({32'h0, 16'hA500 | 16'(i)});
    end
    srcExt.push(48'h0);
    srcExt.push(48'hCAFE_0000_BEEF);
    srcExt.push(48'h1);
    srcExt.push(48'h2);
    for (int k = 0; k < 3000 && runApp !== 1'b1; k++) @(posedge core_clk);
    chk(runApp, 1'b1);
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < (at[i][4] ? 1 : 2); j++)
        expw(32'h100 + 4 * i + j, at[i][4] ? 64'hA500 | i : 64'h0, at[i][4] ? 64'hFFFF : '1,
             at[i][3:0]);
    end
    expw(bbsl_pkg::VEC_FIRST, bbsl_pkg::INSTR_RTI, 64'hFFFF_FFFF_FFFF, 4'hB);
    expw(bbsl_pkg::LDR_BASE_RST, 64'h1, '1, 4'hB);
    expw(bbsl_pkg::LDR_BASE_RST + 1, 64'h2, '1, 4'hB);
    chk(qa.size(), 0);
    chk(wideTransferRegister, 48'hCAFE_0000_BEEF);
    rd(bbsl_pkg::REG_WIDE_HI);
    chk(rv, 32'hCAFE);
    chk(runAddr, bbsl_pkg::VEC_SECOND);
    chk({systemConfigRegister, dmaChannelControl}, 64'h10_0000_0000);
    chk(linkPortControl, 32'h0);
  endtask
  task t_error;
    wr(bbsl_pkg::REG_CTRL, 32'h3);
    srcLnk.push({32'h0, 16'h0006});
    srcLnk.push(48'h0);
    repeat (30) @(posedge core_clk);
    rd(bbsl_pkg::REG_STAT);
    chk(rv[1], 1'b1);
    chk(qa.size(), 0);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    memReady = 1'b0;
    slowSrc = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_noboot();
    t_boot();
    t_error();
    end_sim();
  end
  // boot run is a few hundred cycles; this margin only catches a hang
  initial begin
    repeat (8000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end
endmodule
